// [rtl/asri_regs.sv]
// Result words, scan events, clipping and limit requests with a classic Wishbone slave and one interrupt line.
`timescale 1ns/1ps

// Notes on behaviour
// - Result bits 15:0 copied from the working value only when the whole scan finishes.
// - Bit 27 set when the channel got valid data last scan; averaging ORs valid bits.
// - Bit 29 set when the raw pre-averaging value is all zeros or all ones at the selected resolution.
// - Bit 30 set when the averaged result meets the limit compare condition.
// - Bit 31 set when sampled last scan and, with all channels interleaved, only if averaging reached its count.
// - Result words for channels 0 to 15 sit at consecutive word addresses.
// - A source with mask bit zero never contributes to the interrupt.
// - Interrupt asserts whenever scan flags AND their mask bits is non-zero.
// - A read-only view shows scan flags ANDed with their mask bits.
// - Writing one clears a flag bit; writing zero leaves it unchanged.
// - Scan flag bit 0 sets when a scan of all enabled channels completes.
// - Scan flag bit 1 sets when end of scan sets while still uncleared.
// - In hardware trigger mode a software start while busy sets bit 2 after its scan.
// - A hardware start while busy sets bit 3 after the scan it caused completes.
// - All four scan event mask bits are enabled out of reset.
// - Per-channel clip request bits set on all-zero or all-one raw values, width per resolution.
// - Per-channel clip mask is writable and resets to a configured selection.
// - Clip requests ANDed with clip mask are readable; non-zero raises the interrupt.
// - Per-channel limit request bits set when the averaged result meets the compare.
// - Per-channel limit mask is writable and resets to a configured selection.
// - Limit requests ANDed with limit mask are readable; non-zero raises the interrupt.
// - With all channels interleaved, end of scan waits for the averaging count of scans.
module asri_regs #(
  parameter logic [15:0] CLIP_MASK_INIT = 16'h0000,
  parameter logic [15:0] LIMIT_MASK_INIT = 16'h0000,
  parameter int NUM_CHAN = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [6:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire asri_pkg::asri_conv_t conv_i,
  input wire asri_pkg::asri_scan_t scan_i,
  output logic irq_o
);

  typedef struct packed {
    logic [NUM_CHAN-1:0][31:0] result;
    logic [NUM_CHAN-1:0][15:0] work;
    logic [NUM_CHAN-1:0] work_valid;
    logic [NUM_CHAN-1:0] work_clip;
    logic [NUM_CHAN-1:0] work_limit;
    logic [NUM_CHAN-1:0] work_upd;
    logic [NUM_CHAN-1:0] sampled;
    logic [3:0] evt_flags;
    logic [3:0] evt_en;
    logic [15:0] clip_flags;
    logic [15:0] clip_en;
    logic [15:0] lim_flags;
    logic [15:0] lim_en;
    logic [31:0] thresh;
    logic [31:0] ctrl;
    logic [4:0] scan_cnt;
    logic busy_d;
    logic fw_wait;
    logic fw_armed;
    logic hw_wait;
    logic hw_armed;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } asri_state_t;

  asri_state_t s_r;
  asri_state_t s_nxt;

  function automatic logic [31:0] asri_lanes(input logic [3:0] sel);
    asri_lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic asri_clipped(input logic [11:0] raw, input logic [1:0] res);
    logic [11:0] ones;
    ones = asri_pkg::RAW_ALL_ONES;
    if (res == asri_pkg::ASRI_RES_10)
    begin
      ones = {2'b00, asri_pkg::RAW_ALL_ONES[9:0]};
    end
    else if (res == asri_pkg::ASRI_RES_8)
    begin
      ones = {4'h0, asri_pkg::RAW_ALL_ONES[7:0]};
    end
    asri_clipped = ((raw & ones) == 12'h000) || ((raw & ones) == ones);
  endfunction

  function automatic logic asri_in_limit(input logic [15:0] v, input logic [31:0] th, input logic [1:0] mode);
    logic below;
    logic above;
    below = v < th[15:0];
    above = v >= th[31:16];
    case (mode)
      asri_pkg::ASRI_CMP_BELOW: asri_in_limit = below;
      asri_pkg::ASRI_CMP_INSIDE: asri_in_limit = !below && !above;
      asri_pkg::ASRI_CMP_ABOVE: asri_in_limit = above;
      default: asri_in_limit = below || above;
    endcase
  endfunction

  logic wr_now;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic eos_hit;
  logic scan_start;
  logic interleaved_all;
  logic [4:0] avg_count;

  always_comb
  begin
    s_nxt = s_r;
    interleaved_all = s_r.ctrl[4];
    avg_count = s_r.ctrl[12:8];
    wr_now = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
    wmask = asri_lanes(wb_sel_i);
    wbits = wb_dat_i & wmask;
    scan_start = scan_i.busy && !s_r.busy_d;
    eos_hit = 1'b0;
    s_nxt.busy_d = scan_i.busy;

    // Software writes; hardware sets below take priority over these clears.
    if (wr_now)
    begin
      if (wb_adr_i == asri_pkg::OFS_EVT_FLAGS)
      begin
        s_nxt.evt_flags = s_r.evt_flags & ~wbits[3:0];
      end
      else if (wb_adr_i == asri_pkg::OFS_EVT_ENABLES)
      begin
        s_nxt.evt_en = (s_r.evt_en & ~wmask[3:0]) | wbits[3:0];
      end
      else if (wb_adr_i == asri_pkg::OFS_CLIP_FLAGS)
      begin
        s_nxt.clip_flags = s_r.clip_flags & ~wbits[15:0];
      end
      else if (wb_adr_i == asri_pkg::OFS_CLIP_ENABLE)
      begin
        s_nxt.clip_en = (s_r.clip_en & ~wmask[15:0]) | wbits[15:0];
      end
      else if (wb_adr_i == asri_pkg::OFS_LIM_FLAGS)
      begin
        s_nxt.lim_flags = s_r.lim_flags & ~wbits[15:0];
      end
      else if (wb_adr_i == asri_pkg::OFS_LIM_ENABLE)
      begin
        s_nxt.lim_en = (s_r.lim_en & ~wmask[15:0]) | wbits[15:0];
      end
      else if (wb_adr_i == asri_pkg::OFS_LIM_THRESH)
      begin
        s_nxt.thresh = (s_r.thresh & ~wmask) | wbits;
      end
      else if (wb_adr_i == asri_pkg::OFS_CTRL)
      begin
        s_nxt.ctrl = ((s_r.ctrl & ~wmask) | wbits) & 32'h0000_1f1f;
      end
    end

    // Trigger collisions wait for the scan they caused before flagging.
    if (scan_i.sw_start && scan_i.busy && scan_i.hw_mode)
    begin
      s_nxt.fw_wait = 1'b1;
    end
    if (scan_i.hw_soc && scan_i.busy)
    begin
      s_nxt.hw_wait = 1'b1;
    end
    if (scan_start && s_r.fw_wait)
    begin
      s_nxt.fw_armed = 1'b1;
      s_nxt.fw_wait = 1'b0;
    end
    if (scan_start && s_r.hw_wait)
    begin
      s_nxt.hw_armed = 1'b1;
      s_nxt.hw_wait = 1'b0;
    end

    // Each finished conversion updates its channel's working copy.
    if (conv_i.valid)
    begin
      s_nxt.work[conv_i.chan] = conv_i.avg;
      s_nxt.sampled[conv_i.chan] = 1'b1;
      s_nxt.work_valid[conv_i.chan] = (s_r.sampled[conv_i.chan] && s_r.work_valid[conv_i.chan])
        || conv_i.data_ok;
      s_nxt.work_upd[conv_i.chan] = conv_i.avg_done;
      s_nxt.work_clip[conv_i.chan] = (s_r.sampled[conv_i.chan] && s_r.work_clip[conv_i.chan])
        || asri_clipped(conv_i.raw, s_r.ctrl[3:2]);
      s_nxt.work_limit[conv_i.chan] = conv_i.avg_done && asri_in_limit(conv_i.avg, s_r.thresh, s_r.ctrl[1:0]);
      if (asri_clipped(conv_i.raw, s_r.ctrl[3:2]))
      begin
        s_nxt.clip_flags[conv_i.chan] = 1'b1;
      end
      if (conv_i.avg_done && asri_in_limit(conv_i.avg, s_r.thresh, s_r.ctrl[1:0]))
      begin
        s_nxt.lim_flags[conv_i.chan] = 1'b1;
      end
    end

    // At scan end the working copies move into the result words.
    if (scan_i.scan_done)
    begin
      if (interleaved_all)
      begin
        if (s_r.scan_cnt + 5'h01 >= avg_count)
        begin
          eos_hit = 1'b1;
          s_nxt.scan_cnt = asri_pkg::SCAN_CNT_RST;
        end
        else
        begin
          s_nxt.scan_cnt = s_r.scan_cnt + 5'h01;
        end
      end
      else
      begin
        eos_hit = 1'b1;
      end
    end
    if (eos_hit)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        if (s_r.sampled[i])
        begin
          s_nxt.result[i][15:0] = s_r.work[i];
        end
        s_nxt.result[i][asri_pkg::RES_VALID_BIT] = s_r.sampled[i] && s_r.work_valid[i];
        s_nxt.result[i][asri_pkg::RES_CLIP_BIT] = s_r.sampled[i] && s_r.work_clip[i];
        s_nxt.result[i][asri_pkg::RES_LIMIT_BIT] = s_r.sampled[i] && s_r.work_limit[i];
        s_nxt.result[i][asri_pkg::RES_UPDATED_BIT] = s_r.sampled[i] && (s_r.work_upd[i] || !interleaved_all);
      end
      s_nxt.sampled = '0;
      if (s_r.evt_flags[asri_pkg::EVT_EOS_BIT])
      begin
        s_nxt.evt_flags[asri_pkg::EVT_OVF_BIT] = 1'b1;
      end
      s_nxt.evt_flags[asri_pkg::EVT_EOS_BIT] = 1'b1;
    end
    if (scan_i.scan_done && s_r.fw_armed)
    begin
      s_nxt.evt_flags[asri_pkg::EVT_FW_BIT] = 1'b1;
      s_nxt.fw_armed = 1'b0;
    end
    if (scan_i.scan_done && s_r.hw_armed)
    begin
      s_nxt.evt_flags[asri_pkg::EVT_HW_BIT] = 1'b1;
      s_nxt.hw_armed = 1'b0;
    end

    // Registered Wishbone answer, one wait cycle per access.
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.rdata = 32'h0000_0000;
    if (wb_adr_i <= asri_pkg::OFS_RESULT_15)
    begin
      s_nxt.rdata = s_r.result[wb_adr_i[5:2]];
    end
    else if (wb_adr_i == asri_pkg::OFS_EVT_FLAGS)
    begin
      s_nxt.rdata = {28'h0000000, s_r.evt_flags};
    end
    else if (wb_adr_i == asri_pkg::OFS_EVT_ENABLES)
    begin
      s_nxt.rdata = {28'h0000000, s_r.evt_en};
    end
    else if (wb_adr_i == asri_pkg::OFS_EVT_PENDING)
    begin
      s_nxt.rdata = {28'h0000000, s_r.evt_flags & s_r.evt_en};
    end
    else if (wb_adr_i == asri_pkg::OFS_CLIP_FLAGS)
    begin
      s_nxt.rdata = {16'h0000, s_r.clip_flags};
    end
    else if (wb_adr_i == asri_pkg::OFS_CLIP_ENABLE)
    begin
      s_nxt.rdata = {16'h0000, s_r.clip_en};
    end
    else if (wb_adr_i == asri_pkg::OFS_CLIP_PENDING)
    begin
      s_nxt.rdata = {16'h0000, s_r.clip_flags & s_r.clip_en};
    end
    else if (wb_adr_i == asri_pkg::OFS_LIM_FLAGS)
    begin
      s_nxt.rdata = {16'h0000, s_r.lim_flags};
    end
    else if (wb_adr_i == asri_pkg::OFS_LIM_ENABLE)
    begin
      s_nxt.rdata = {16'h0000, s_r.lim_en};
    end
    else if (wb_adr_i == asri_pkg::OFS_LIM_PENDING)
    begin
      s_nxt.rdata = {16'h0000, s_r.lim_flags & s_r.lim_en};
    end
    else if (wb_adr_i == asri_pkg::OFS_LIM_THRESH)
    begin
      s_nxt.rdata = s_r.thresh;
    end
    else if (wb_adr_i == asri_pkg::OFS_CTRL)
    begin
      s_nxt.rdata = s_r.ctrl;
    end
    s_nxt.rdata = (wb_cyc_i && wb_stb_i && !s_r.ack) ? s_nxt.rdata : s_r.rdata;

    // Interrupt follows the next flag values so it lines up with them.
    s_nxt.irq = (|(s_nxt.evt_flags & s_nxt.evt_en))
      || (|(s_nxt.clip_flags & s_nxt.clip_en))
      || (|(s_nxt.lim_flags & s_nxt.lim_en));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.evt_en <= asri_pkg::EVT_ENABLES_RST;
      s_r.clip_en <= CLIP_MASK_INIT;
      s_r.lim_en <= LIMIT_MASK_INIT;
      s_r.thresh <= asri_pkg::THRESH_RST;
      s_r.ctrl <= asri_pkg::CTRL_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdata;
  assign wb_ack_o = s_r.ack;
  assign irq_o = s_r.irq;

endmodule

// [rtl/asri_pkg.sv]
// Package with register map, field positions, reset values and carrier types of the result and interrupt block.
package asri_pkg;
  localparam logic [6:0] OFS_RESULT_0 = 7'h00;
  localparam logic [6:0] OFS_RESULT_15 = 7'h3c;
  localparam logic [6:0] OFS_EVT_FLAGS = 7'h40;
  localparam logic [6:0] OFS_EVT_ENABLES = 7'h44;
  localparam logic [6:0] OFS_EVT_PENDING = 7'h48;
  localparam logic [6:0] OFS_CLIP_FLAGS = 7'h4c;
  localparam logic [6:0] OFS_CLIP_ENABLE = 7'h50;
  localparam logic [6:0] OFS_CLIP_PENDING = 7'h54;
  localparam logic [6:0] OFS_LIM_FLAGS = 7'h58;
  localparam logic [6:0] OFS_LIM_ENABLE = 7'h5c;
  localparam logic [6:0] OFS_LIM_PENDING = 7'h60;
  localparam logic [6:0] OFS_LIM_THRESH = 7'h64;
  localparam logic [6:0] OFS_CTRL = 7'h68;
  localparam int RES_VALID_BIT = 27;
  localparam int RES_CLIP_BIT = 29;
  localparam int RES_LIMIT_BIT = 30;
  localparam int RES_UPDATED_BIT = 31;
  localparam int EVT_EOS_BIT = 0;
  localparam int EVT_OVF_BIT = 1;
  localparam int EVT_FW_BIT = 2;
  localparam int EVT_HW_BIT = 3;
  localparam logic [3:0] EVT_ENABLES_RST = 4'hf;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] THRESH_RST = 32'hffff_0000;
  localparam logic [11:0] RAW_ALL_ONES = 12'hfff;
  localparam logic [4:0] SCAN_CNT_RST = 5'h00;

  typedef enum logic [1:0] {
    ASRI_CMP_BELOW = 2'b00,
    ASRI_CMP_INSIDE = 2'b01,
    ASRI_CMP_ABOVE = 2'b10,
    ASRI_CMP_OUTSIDE = 2'b11
  } asri_cmp_t;

  typedef enum logic [1:0] {
    ASRI_RES_12 = 2'b00,
    ASRI_RES_10 = 2'b01,
    ASRI_RES_8 = 2'b10
  } asri_res_t;

  // One finished conversion handed over by the sequencer.
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [11:0] raw;
    logic data_ok;
    logic [15:0] avg;
    logic avg_done;
  } asri_conv_t;

  // Scan status handed over by the sequencer.
  typedef struct packed {
    logic scan_done;
    logic busy;
    logic hw_mode;
    logic sw_start;
    logic hw_soc;
  } asri_scan_t;
endpackage

// [verification/asri_regs_assertions.sv]
// Checker of bus handshake, read data and interrupt causes of the result and interrupt block.
`timescale 1ns/1ps
module asri_regs_assertions #(
  parameter logic [15:0] CLIP_MASK_INIT = 16'h0000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [6:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire asri_pkg::asri_conv_t conv_i,
  input wire asri_pkg::asri_scan_t scan_i,
  input wire logic irq_o
);
  logic [3:0] evt_en_r;
  logic [15:0] clip_en_r;
  logic il_r;
  logic wr_ack;
  logic clip_hit;
  assign wr_ack = wb_ack_o && wb_we_i;
  assign clip_hit = conv_i.valid && (conv_i.raw == 12'hfff || conv_i.raw == 12'h000);
  // Shadow copies of the event and clip enables and the interleave bit, taken at the write's ack edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      evt_en_r <= asri_pkg::EVT_ENABLES_RST;
      clip_en_r <= CLIP_MASK_INIT;
      il_r <= asri_pkg::CTRL_RST[4];
    end
    else if (wr_ack)
    begin
      if (wb_sel_i[0] && wb_adr_i[6:2] == asri_pkg::OFS_EVT_ENABLES[6:2]) evt_en_r <= wb_dat_i[3:0];
      if (wb_sel_i[0] && wb_adr_i[6:2] == asri_pkg::OFS_CLIP_ENABLE[6:2]) clip_en_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1] && wb_adr_i[6:2] == asri_pkg::OFS_CLIP_ENABLE[6:2]) clip_en_r[15:8] <= wb_dat_i[15:8];
      if (wb_sel_i[0] && wb_adr_i[6:2] == asri_pkg::OFS_CTRL[6:2]) il_r <= wb_dat_i[4];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > asri_pkg::OFS_CTRL |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data changed outside ack");
  eos_irq_a: assert property (scan_i.scan_done && evt_en_r[0] && !il_r && !wr_ack |=> irq_o)
    else $error("end of scan did not raise interrupt");
  clip_irq_a: assert property (clip_hit && clip_en_r[conv_i.chan] && !wr_ack |=> irq_o)
    else $error("clip did not raise interrupt");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(scan_i.scan_done || conv_i.valid || wr_ack))
    else $error("interrupt rose without cause");
  irq_drop_a: assert property ($fell(irq_o) |-> $past(wr_ack))
    else $error("interrupt fell without write");
  scan_c: cover property (scan_i.scan_done);
  clip_c: cover property (clip_hit);
  read_c: cover property (wb_ack_o && !wb_we_i);
endmodule
bind asri_regs asri_regs_assertions #(.CLIP_MASK_INIT(CLIP_MASK_INIT)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_i(conv_i), .scan_i(scan_i), .irq_o(irq_o));

// [verification/asri_regs_bench.sv]
// Self-checking bench of the result and interrupt block.
`timescale 1ns/1ps
module asri_regs_bench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [6:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, v, rs;
  logic [15:0] x;
  logic l;
  asri_pkg::asri_conv_t conv_i;
  asri_pkg::asri_scan_t scan_i;
  logic [31:0] exp_q[$];
  int errors, total_checks;
  asri_regs #(.CLIP_MASK_INIT(16'h000f), .LIMIT_MASK_INIT(16'h0000)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_i(conv_i), .scan_i(scan_i), .irq_o(irq_o));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Classic cycle: request held until the edge that samples ack.
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic cv(input logic [3:0] ch, input logic [11:0] raw, input logic [15:0] avg);
    @(posedge clk_i);
    conv_i <= {1'b1, ch, raw, 1'b1, avg, 1'b1};
    @(posedge clk_i);
    conv_i <= '0;
  endtask
  task automatic eos();
    @(posedge clk_i);
    scan_i.scan_done <= 1'b1;
    @(posedge clk_i);
    scan_i.scan_done <= 1'b0;
  endtask
  task automatic st(input logic [4:0] s);
    @(posedge clk_i);
    scan_i <= s;
  endtask
  task automatic ic(input logic e);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask
  // Read data is compared with the oldest expectation at its ack edge.
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk(wb_dat_o, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    finish_test();
  end
  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 7'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    conv_i = '0;
    scan_i = '0;
    rs = 32'he5c9;
    errors = 0;
    total_checks = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(asri_pkg::OFS_EVT_ENABLES, 32'hf);
    rd(asri_pkg::OFS_CLIP_ENABLE, 32'hf);
    rd(asri_pkg::OFS_LIM_ENABLE, 32'h0);
    rd(7'h7c, 32'h0);
    ic(1'b0);
    $display("reset test done");
    v = rnd();
    cv(4'h3, 12'hfff, v[15:0]);
    cv(4'h5, 12'h000, v[31:16]);
    rd(asri_pkg::OFS_CLIP_FLAGS, 32'h28);
    rd(asri_pkg::OFS_CLIP_PENDING, 32'h8);
    eos();
    rd(7'h0c, {16'ha800, v[15:0]});
    rd(7'h14, {16'ha800, v[31:16]});
    rd(asri_pkg::OFS_EVT_FLAGS, 32'h1);
    rd(asri_pkg::OFS_EVT_PENDING, 32'h1);
    wr(asri_pkg::OFS_CLIP_FLAGS, 32'h28);
    rd(asri_pkg::OFS_CLIP_FLAGS, 32'h0);
    ic(1'b1);
    $display("scan test done");
    eos();
    rd(asri_pkg::OFS_EVT_FLAGS, 32'h3);
    rd(7'h0c, {16'h0, v[15:0]});
    wr(asri_pkg::OFS_EVT_FLAGS, 32'h1);
    rd(asri_pkg::OFS_EVT_FLAGS, 32'h2);
    wr(asri_pkg::OFS_EVT_ENABLES, 32'h0);
    rd(asri_pkg::OFS_EVT_PENDING, 32'h0);
    ic(1'b0);
    wr(asri_pkg::OFS_EVT_FLAGS, 32'h2);
    wr(asri_pkg::OFS_EVT_ENABLES, 32'hf);
    $display("overflow test done");
    wr(asri_pkg::OFS_LIM_THRESH, 32'hffff_0100);
    wr(asri_pkg::OFS_LIM_ENABLE, 32'hffff);
    rd(asri_pkg::OFS_LIM_ENABLE, 32'hffff);
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      x = i[2] ? (i[0] ? 16'hffff : 16'h0050) : v[15:0];
      l = (i[1:0] == 2'd0) ? (x < 16'h0100) : (i[1:0] == 2'd1) ? (x >= 16'h0100 && x < 16'hffff) :
          (i[1:0] == 2'd2) ? (x >= 16'hffff) : (x < 16'h0100 || x >= 16'hffff);
      wr(asri_pkg::OFS_CTRL, {30'h40, i[1:0]});
      cv(4'h2, 12'h123, x);
      ic(l);
      rd(asri_pkg::OFS_LIM_FLAGS, {29'h0, l, 2'b00});
      rd(asri_pkg::OFS_LIM_PENDING, {29'h0, l, 2'b00});
      wr(asri_pkg::OFS_LIM_FLAGS, 32'h4);
    end
    $display("limit test done");
    st(5'b01100);
    st(5'b01111);
    st(5'b10100);
    st(5'b01100);
    rd(asri_pkg::OFS_EVT_FLAGS, 32'h1);
    st(5'b10100);
    st(5'b00000);
    rd(asri_pkg::OFS_EVT_FLAGS, 32'hf);
    wr(asri_pkg::OFS_EVT_FLAGS, 32'hf);
    $display("collision test done");
    wr(asri_pkg::OFS_CTRL, 32'h0000_0214);
    eos();
    rd(asri_pkg::OFS_EVT_FLAGS, 32'h0);
    cv(4'h1, 12'h3ff, 16'h1234);
    eos();
    rd(asri_pkg::OFS_EVT_FLAGS, 32'h1);
    rd(7'h04, 32'ha800_1234);
    rd(asri_pkg::OFS_CLIP_FLAGS, 32'h2);
    $display("averaging test done");
    repeat (2) @(posedge clk_i);
    finish_test();
  end
endmodule
